// *** vfm_cfg.svh ***
/*
  Constants of the vector float min/multiply unit: instruction fields,
  opcodes, saturation values and status bit positions.
  Assumes big-endian field numbering mapped onto [31:0] words.
*/
`ifndef VFM_CFG_SVH
`define VFM_CFG_SVH
// ****************************************
// Instruction fields
// ****************************************
`define VFM_PRIM_MSB 31
`define VFM_PRIM_LSB 26
`define VFM_DEST_MSB 25
`define VFM_DEST_LSB 21
`define VFM_XO_MSB 10
`define VFM_PRIMARY_OP 6'h04
`define VFM_XO_MULE 11'h2ae
`define VFM_XO_MULO 11'h2af
`define VFM_XO_MIN 11'h2b1
`define VFM_XO_MSUB 11'h2b3
`define VFM_XO_MUL 11'h2b8
// ****************************************
// Values
// ****************************************
`define VFM_PMAX 32'h7f7fffff
`define VFM_NMAX 32'hff7fffff
`define VFM_POS_ZERO 32'h00000000
`define VFM_NEG_ZERO 32'h80000000
`define VFM_EXP_ALL1 8'hff
`define VFM_BIAS 10'h07f
`define VFM_EXP_OVF 10'h0ff
`define VFM_RESULT_RST 64'h0000000000000000
`define VFM_STATUS_RST 11'h000
// ****************************************
// Status bit positions
// ****************************************
`define VFM_ST_INV_HI 0
`define VFM_ST_INV_LO 1
`define VFM_ST_OVF_HI 2
`define VFM_ST_OVF_LO 3
`define VFM_ST_UNF_HI 4
`define VFM_ST_UNF_LO 5
`define VFM_ST_G_HI 6
`define VFM_ST_G_LO 7
`define VFM_ST_X_HI 8
`define VFM_ST_X_LO 9
`define VFM_ST_INXS 10
`endif

// *** vfm_pkg.sv ***
/*
  Types of the vector float min/multiply unit.
  Assumes nothing beyond the constants header.
*/
package vfm_pkg;
  typedef enum logic [2:0] {
    VFM_OP_NONE = 3'h0,
    VFM_OP_MIN = 3'h1,
    VFM_OP_MSUB = 3'h2,
    VFM_OP_MUL = 3'h3,
    VFM_OP_MULE = 3'h4,
    VFM_OP_MULO = 3'h5
  } vfm_op_type;
  typedef enum logic [1:0] {
    VFM_RND_NEAR = 2'h0,
    VFM_RND_ZERO = 2'h1,
    VFM_RND_POS = 2'h2,
    VFM_RND_NEG = 2'h3
  } vfm_round_type;
  typedef struct packed {
    logic sign;
    logic [9:0] exp;
    logic [47:0] mant;
    logic zero;
  } vfm_unpacked_type;
  typedef struct packed {
    logic [31:0] value;
    logic guard;
    logic sticky;
    logic inexact;
    logic ovf;
    logic unf;
  } vfm_rounded_type;
endpackage

// *** vfm_lane_mul.sv ***
/*
  One lane multiplier: exact 48-bit product, special operand cases.
  Assumes the caller rounds and packs the product.
*/
`timescale 1ns/1ps
`include "vfm_cfg.svh"
module vfm_lane_mul (
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  output vfm_pkg::vfm_unpacked_type product,
  output logic zero_case,
  output logic sat_case,
  output logic [31:0] sat_value
);
  // ****************************************
  // Operand fields
  // ****************************************
  wire sign_p = op_a[31] ^ op_b[31];
  wire [7:0] exp_a = op_a[30:23];
  wire [7:0] exp_b = op_b[30:23];
  wire a_zd = exp_a == 8'h00;
  wire b_zd = exp_b == 8'h00;
  wire a_ni = exp_a == `VFM_EXP_ALL1;
  wire b_ni = exp_b == `VFM_EXP_ALL1;
  wire [23:0] man_a = {1'b1, op_a[22:0]};
  wire [23:0] man_b = {1'b1, op_b[22:0]};
  // ****************************************
  // Product
  // ****************************************
  wire [47:0] raw = man_a * man_b;
  wire [47:0] mant_n = raw[47] ? raw : {raw[46:0], 1'b0};
  wire [9:0] exp_p = {2'h0, exp_a} + {2'h0, exp_b} - `VFM_BIAS
    + {9'h000, raw[47]};
  assign zero_case = a_zd | b_zd;
  assign sat_case = ~zero_case & (a_ni | b_ni);
  assign sat_value = sign_p ? `VFM_NMAX : `VFM_PMAX;
  assign product = {sign_p, exp_p, mant_n, zero_case};
endmodule

// *** vfm_lane_min.sv ***
/*
  One lane minimum with raw-field compare and result clean-up.
  Assumes invalid-input detection is done by the caller.
*/
`timescale 1ns/1ps
`include "vfm_cfg.svh"
module vfm_lane_min (
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  output logic [31:0] result
);
  // ****************************************
  // Compare
  // ****************************************
  wire a_nan = (op_a[30:23] == `VFM_EXP_ALL1) & (op_a[22:0] != 23'h0);
  wire b_nan = (op_b[30:23] == `VFM_EXP_ALL1) & (op_b[22:0] != 23'h0);
  wire mag_lt = op_a[30:0] < op_b[30:0];
  wire mag_gt = op_a[30:0] > op_b[30:0];
  wire a_less = (op_a[31] != op_b[31]) ? op_a[31]
    : (op_a[31] ? mag_gt : mag_lt);
  wire [31:0] pick = (a_nan & ~b_nan) ? op_b
    : (b_nan & ~a_nan) ? op_a
    : (a_less ? op_a : op_b);
  // ****************************************
  // Clean-up of the choice
  // ****************************************
  wire pick_zd = pick[30:23] == 8'h00;
  wire pick_ni = pick[30:23] == `VFM_EXP_ALL1;
  wire [31:0] sat = pick[31] ? `VFM_NMAX : `VFM_PMAX;
  assign result = pick_zd ? {pick[31], 31'h0}
    : (pick_ni ? sat : pick);
endmodule

// *** vfm_exec.sv ***
/*
  Vector single-precision min / multiply-subtract / multiply unit.
  Takes one issued instruction per cycle with its operands, answers
  one cycle later with the result, write strobe and status bits.
  Assumes the issue logic supplies the old destination value.
*/
// How it works
// - Minimum picks smaller lane; zeros give negative
// - Special min inputs flag invalid; trap blocks write
// - Untrapped min compares raw exponent and fraction
// - One NaN lane: pick the other lane
// - Denormal to signed zero, NaN/inf saturates
// - Multiply-subtract: product minus destination lane
// - Zero/denormal operand gives negated destination lane; NaN/inf saturates directly
// - NaN/inf destination lane saturates by inverted sign
// - Subtract underflow gives +0, or -0 rounding down
// - Overflow saturates to signed largest normal
// - Subtract invalid check includes destination lanes
// - Overflow/underflow flags; enabled trap blocks write
// - Inexact sticky on inexact or untrapped range
// - Inexact trap writes truncated, keeps guard/sticky
// - Multiply pairs high with high, low with low
// - Multiply special operands: zero or saturation
// - High-element form uses first high lane
// - Low-element form uses first low lane
// - Element forms handle specials per lane
// - Element forms check only used first lane
// - Decode primary and extended opcode fields
`timescale 1ns/1ps
`include "vfm_cfg.svh"
module vfm_exec (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic [63:0] first_source,
  input wire logic [63:0] second_source,
  input wire logic [63:0] dest_source,
  input wire vfm_pkg::vfm_round_type round_mode,
  input wire logic invalid_input_trap_enable,
  input wire logic overflow_trap_enable,
  input wire logic underflow_trap_enable,
  input wire logic inexact_trap_enable,
  input wire logic inexact_sticky_clear,
  output logic result_valid,
  output logic dest_write,
  output logic [4:0] dest_index,
  output logic [63:0] dest_result,
  output logic invalid_exception,
  output logic range_exception,
  output logic round_exception,
  output logic invalid_input_flag_hi,
  output logic invalid_input_flag_lo,
  output logic overflow_flag_hi,
  output logic overflow_flag_lo,
  output logic underflow_flag_hi,
  output logic underflow_flag_lo,
  output logic guard_bit_hi,
  output logic guard_bit_lo,
  output logic sticky_bit_hi,
  output logic sticky_bit_lo,
  output logic inexact_sticky_flag
);
  // ****************************************
  // Functions
  // ****************************************
  function automatic logic is_special(input logic [31:0] x);
    begin
      is_special = (x[30:23] == `VFM_EXP_ALL1)
        | ((x[30:23] == 8'h00) & (x[22:0] != 23'h0));
    end
  endfunction

  function automatic vfm_pkg::vfm_rounded_type round_pack(
    input vfm_pkg::vfm_unpacked_type u,
    input vfm_pkg::vfm_round_type mode,
    input logic trunc,
    input logic by_mode
  );
    vfm_pkg::vfm_rounded_type r;
    logic g;
    logic x;
    logic inc;
    logic [24:0] frac_r;
    logic [9:0] exp_r;
    begin
      g = u.mant[23];
      x = |u.mant[22:0];
      case (mode)
        vfm_pkg::VFM_RND_NEAR: inc = g & (x | u.mant[24]);
        vfm_pkg::VFM_RND_POS: inc = ~u.sign & (g | x);
        vfm_pkg::VFM_RND_NEG: inc = u.sign & (g | x);
        default: inc = 1'b0;
      endcase
      if (trunc) begin
        inc = 1'b0;
      end
      frac_r = {1'b0, u.mant[47:24]} + {24'h000000, inc};
      exp_r = u.exp + {9'h000, frac_r[24]};
      r.guard = g;
      r.sticky = x;
      r.inexact = g | x;
      r.ovf = 1'b0;
      r.unf = 1'b0;
      if (u.zero) begin
        r.value = {u.sign, 31'h0};
        r.guard = 1'b0;
        r.sticky = 1'b0;
        r.inexact = 1'b0;
      end else if ($signed(u.exp) <= 0) begin
        r.unf = 1'b1;
        if (by_mode) begin
          r.value = (mode == vfm_pkg::VFM_RND_NEG) ? `VFM_NEG_ZERO
            : `VFM_POS_ZERO;
        end else begin
          r.value = {u.sign, 31'h0};
        end
      end else if ($signed(exp_r) >= $signed(`VFM_EXP_OVF)) begin
        r.ovf = 1'b1;
        r.value = u.sign ? `VFM_NMAX : `VFM_PMAX;
      end else begin
        r.value = {u.sign, exp_r[7:0],
          frac_r[24] ? frac_r[23:1] : frac_r[22:0]};
      end
      round_pack = r;
    end
  endfunction

  function automatic vfm_pkg::vfm_unpacked_type sub_dest(
    input vfm_pkg::vfm_unpacked_type p,
    input logic [31:0] d,
    input logic neg_zero
  );
    vfm_pkg::vfm_unpacked_type q;
    vfm_pkg::vfm_unpacked_type big;
    vfm_pkg::vfm_unpacked_type lesser;
    vfm_pkg::vfm_unpacked_type r;
    logic [95:0] sh;
    logic [9:0] diff;
    logic [47:0] al;
    logic [48:0] sum;
    logic [5:0] lz;
    logic found;
    integer i;
    begin
      q.sign = ~d[31];
      q.exp = {2'h0, d[30:23]};
      q.mant = {1'b1, d[22:0], 24'h000000};
      q.zero = d[30:23] == 8'h00;
      r = p;
      lz = 6'h00;
      found = 1'b0;
      if (q.zero) begin
        r = p;
      end else if (p.zero) begin
        r = q;
      end else begin
        if (($signed(p.exp) > $signed(q.exp))
            || ((p.exp == q.exp) && (p.mant >= q.mant))) begin
          big = p;
          lesser = q;
        end else begin
          big = q;
          lesser = p;
        end
        diff = big.exp - lesser.exp;
        sh = {lesser.mant, 48'h0} >> ((diff > 10'd63) ? 10'd63 : diff);
        al = sh[95:48] | {47'h0, |sh[47:0]};
        if (big.sign == lesser.sign) begin
          sum = {1'b0, big.mant} + {1'b0, al};
        end else begin
          sum = {1'b0, big.mant} - {1'b0, al};
        end
        r.sign = big.sign;
        r.zero = 1'b0;
        r.exp = big.exp;
        if (sum[48]) begin
          r.mant = sum[48:1] | {47'h0, sum[0]};
          r.exp = big.exp + 10'h001;
        end else if (sum == 49'h0) begin
          r.zero = 1'b1;
          r.sign = neg_zero;
          r.mant = 48'h0;
        end else begin
          for (i = 47; i >= 0; i--) begin
            if (!found && sum[i]) begin
              found = 1'b1;
              lz = 6'(47 - i);
            end
          end
          r.mant = sum[47:0] << lz;
          r.exp = big.exp - {4'h0, lz};
        end
      end
      sub_dest = r;
    end
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  wire [10:0] xo = instr_word[`VFM_XO_MSB:0];
  wire prim_hit =
    instr_word[`VFM_PRIM_MSB:`VFM_PRIM_LSB] == `VFM_PRIMARY_OP;
  vfm_pkg::vfm_op_type op_dec;
  assign op_dec = !prim_hit ? vfm_pkg::VFM_OP_NONE
    : (xo == `VFM_XO_MIN) ? vfm_pkg::VFM_OP_MIN
    : (xo == `VFM_XO_MSUB) ? vfm_pkg::VFM_OP_MSUB
    : (xo == `VFM_XO_MUL) ? vfm_pkg::VFM_OP_MUL
    : (xo == `VFM_XO_MULE) ? vfm_pkg::VFM_OP_MULE
    : (xo == `VFM_XO_MULO) ? vfm_pkg::VFM_OP_MULO
    : vfm_pkg::VFM_OP_NONE;
  wire op_min = op_dec == vfm_pkg::VFM_OP_MIN;
  wire op_msub = op_dec == vfm_pkg::VFM_OP_MSUB;
  wire op_mule = op_dec == vfm_pkg::VFM_OP_MULE;
  wire op_mulo = op_dec == vfm_pkg::VFM_OP_MULO;
  wire accept = issue_valid & (op_dec != vfm_pkg::VFM_OP_NONE);
  wire neg_mode = round_mode == vfm_pkg::VFM_RND_NEG;

  // ****************************************
  // Lane operands, index 1 is the high lane
  // ****************************************
  logic [31:0] lane_a [2];
  logic [31:0] lane_b [2];
  logic [31:0] lane_d [2];
  assign lane_a[1] = op_mulo ? first_source[31:0]
    : first_source[63:32];
  assign lane_a[0] = op_mule ? first_source[63:32]
    : first_source[31:0];
  assign lane_b[1] = second_source[63:32];
  assign lane_b[0] = second_source[31:0];
  assign lane_d[1] = dest_source[63:32];
  assign lane_d[0] = dest_source[31:0];

  // ****************************************
  // Lane datapaths
  // ****************************************
  vfm_pkg::vfm_unpacked_type prod [2];
  vfm_pkg::vfm_unpacked_type diff_u [2];
  vfm_pkg::vfm_unpacked_type arith_u [2];
  vfm_pkg::vfm_rounded_type rnd [2];
  logic [31:0] min_res [2];
  logic [31:0] sat_val [2];
  logic [31:0] lane_res [2];
  logic [1:0] zero_c;
  logic [1:0] sat_c;
  logic [1:0] d_spec;
  logic [1:0] lane_inv;
  logic [1:0] lane_ovf;
  logic [1:0] lane_unf;
  logic [1:0] lane_inx;
  logic [1:0] lane_g;
  logic [1:0] lane_x;
  logic [1:0] use_rnd;
  genvar g;
  for (g = 0; g < 2; g++) begin : lane
    vfm_lane_mul u_mul (
      .op_a(lane_a[g]),
      .op_b(lane_b[g]),
      .product(prod[g]),
      .zero_case(zero_c[g]),
      .sat_case(sat_c[g]),
      .sat_value(sat_val[g])
    );
    vfm_lane_min u_min (
      .op_a(lane_a[g]),
      .op_b(lane_b[g]),
      .result(min_res[g])
    );
    assign lane_inv[g] = is_special(lane_a[g])
      | is_special(lane_b[g])
      | (op_msub & is_special(lane_d[g]));
    assign d_spec[g] = op_msub & ~zero_c[g] & ~sat_c[g]
      & (lane_d[g][30:23] == `VFM_EXP_ALL1);
    assign diff_u[g] = sub_dest(prod[g], lane_d[g], neg_mode);
    assign arith_u[g] = op_msub ? diff_u[g] : prod[g];
    assign rnd[g] = round_pack(arith_u[g], round_mode,
      inexact_trap_enable, op_msub);
    assign use_rnd[g] = ~op_min & ~sat_c[g] & ~d_spec[g];
    assign lane_res[g] = op_min ? min_res[g]
      : sat_c[g] ? sat_val[g]
      : d_spec[g] ? (lane_d[g][31] ? `VFM_PMAX : `VFM_NMAX)
      : rnd[g].value;
    assign lane_ovf[g] = use_rnd[g] & rnd[g].ovf;
    assign lane_unf[g] = use_rnd[g] & rnd[g].unf;
    assign lane_inx[g] = use_rnd[g] & rnd[g].inexact;
    assign lane_g[g] = use_rnd[g] & rnd[g].guard;
    assign lane_x[g] = use_rnd[g] & rnd[g].sticky;
  end

  // ****************************************
  // Exception decisions
  // ****************************************
  wire inv_any = |lane_inv;
  wire take_inv = inv_any & invalid_input_trap_enable;
  wire [1:0] ovf_l = inv_any ? 2'h0 : lane_ovf;
  wire [1:0] unf_l = inv_any ? 2'h0 : lane_unf;
  wire take_range = (overflow_trap_enable & (|ovf_l))
    | (underflow_trap_enable & (|unf_l));
  wire inx_set = ~take_inv & ~take_range & ((|lane_inx)
    | ((|ovf_l) & ~overflow_trap_enable)
    | ((|unf_l) & ~underflow_trap_enable));
  wire take_round = inx_set & inexact_trap_enable;
  wire do_write = accept & ~take_inv & ~take_range;
  wire [1:0] g_l = inv_any ? 2'h0 : lane_g;
  wire [1:0] x_l = inv_any ? 2'h0 : lane_x;

  // ****************************************
  // Status next value
  // ****************************************
  logic [10:0] status_reg;
  logic [10:0] status_next;
  always_comb begin
    status_next = status_reg;
    if (accept) begin
      status_next[`VFM_ST_INV_HI] = lane_inv[1];
      status_next[`VFM_ST_INV_LO] = lane_inv[0];
      status_next[`VFM_ST_OVF_HI] = ovf_l[1];
      status_next[`VFM_ST_OVF_LO] = ovf_l[0];
      status_next[`VFM_ST_UNF_HI] = unf_l[1];
      status_next[`VFM_ST_UNF_LO] = unf_l[0];
      status_next[`VFM_ST_G_HI] = g_l[1];
      status_next[`VFM_ST_G_LO] = g_l[0];
      status_next[`VFM_ST_X_HI] = x_l[1];
      status_next[`VFM_ST_X_LO] = x_l[0];
    end
    if (inexact_sticky_clear) begin
      status_next[`VFM_ST_INXS] = 1'b0;
    end
    if (accept & inx_set) begin
      status_next[`VFM_ST_INXS] = 1'b1;
    end
  end

  // ****************************************
  // Result registers
  // ****************************************
  logic valid_reg;
  logic write_reg;
  logic inv_exc_reg;
  logic range_exc_reg;
  logic round_exc_reg;
  logic [4:0] index_reg;
  logic [63:0] result_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      valid_reg <= 1'b0;
      write_reg <= 1'b0;
      inv_exc_reg <= 1'b0;
      range_exc_reg <= 1'b0;
      round_exc_reg <= 1'b0;
      index_reg <= 5'h00;
      result_reg <= `VFM_RESULT_RST;
      status_reg <= `VFM_STATUS_RST;
    end else begin
      valid_reg <= accept;
      write_reg <= do_write;
      inv_exc_reg <= accept & take_inv;
      range_exc_reg <= accept & ~take_inv & take_range;
      round_exc_reg <= accept & take_round;
      index_reg <= instr_word[`VFM_DEST_MSB:`VFM_DEST_LSB];
      result_reg <= {lane_res[1], lane_res[0]};
      status_reg <= status_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign result_valid = valid_reg;
  assign dest_write = write_reg;
  assign dest_index = index_reg;
  assign dest_result = result_reg;
  assign invalid_exception = inv_exc_reg;
  assign range_exception = range_exc_reg;
  assign round_exception = round_exc_reg;
  assign invalid_input_flag_hi = status_reg[`VFM_ST_INV_HI];
  assign invalid_input_flag_lo = status_reg[`VFM_ST_INV_LO];
  assign overflow_flag_hi = status_reg[`VFM_ST_OVF_HI];
  assign overflow_flag_lo = status_reg[`VFM_ST_OVF_LO];
  assign underflow_flag_hi = status_reg[`VFM_ST_UNF_HI];
  assign underflow_flag_lo = status_reg[`VFM_ST_UNF_LO];
  assign guard_bit_hi = status_reg[`VFM_ST_G_HI];
  assign guard_bit_lo = status_reg[`VFM_ST_G_LO];
  assign sticky_bit_hi = status_reg[`VFM_ST_X_HI];
  assign sticky_bit_lo = status_reg[`VFM_ST_X_LO];
  assign inexact_sticky_flag = status_reg[`VFM_ST_INXS];
endmodule

// *** vfm_exec_asserts.sv ***
/*
  Port checker of vfm_exec.
  Assumes it is bound onto every vfm_exec instance.
*/
`timescale 1ns/1ps
`include "vfm_cfg.svh"
module vfm_exec_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic issue_valid,
  input wire logic [31:0] instr_word,
  input wire logic [63:0] first_source,
  input wire logic [63:0] second_source,
  input wire logic invalid_input_trap_enable,
  input wire logic inexact_sticky_clear,
  input wire logic result_valid,
  input wire logic dest_write,
  input wire logic [63:0] dest_result,
  input wire logic invalid_exception,
  input wire logic range_exception,
  input wire logic round_exception,
  input wire logic invalid_input_flag_hi,
  input wire logic guard_bit_hi,
  input wire logic sticky_bit_hi,
  input wire logic inexact_sticky_flag
);
  // ****************************************
  // Decode
  // ****************************************
  wire logic [10:0] xo = instr_word[10:0];
  wire logic known = instr_word[31:26] == `VFM_PRIMARY_OP &&
    (xo == `VFM_XO_MULE || xo == `VFM_XO_MULO || xo == `VFM_XO_MIN ||
    xo == `VFM_XO_MSUB || xo == `VFM_XO_MUL);
  wire logic acc = issue_valid && known;
  wire logic [7:0] be = second_source[62:55];
  wire logic mul_inf = acc && xo == `VFM_XO_MUL &&
    first_source[62:55] == 8'hff && be != 8'h00 && be != 8'hff &&
    !invalid_input_trap_enable;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_accept;
    acc;
  endsequence
  sequence s_answer;
    result_valid;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  a_answer_next: assert property (s_accept |=> s_answer)
    else $error("no result after accepted instruction");
  a_refused_quiet: assert property (!acc |=> !result_valid)
    else $error("result without accepted instruction");
  a_inv_no_write: assert property (invalid_exception |-> !dest_write)
    else $error("write despite invalid trap");
  a_range_no_write: assert property (range_exception |-> !dest_write)
    else $error("write despite range trap");
  a_round_writes: assert property (round_exception |-> dest_write)
    else $error("round trap without write");
  a_inv_clears_gs: assert property (result_valid && invalid_input_flag_hi
    |-> !guard_bit_hi && !sticky_bit_hi)
    else $error("guard or sticky left set on invalid");
  a_mul_sat_hi: assert property (mul_inf |=> dest_result[63:32] ==
    ($past(first_source[63]) == $past(second_source[63]) ?
    `VFM_PMAX : `VFM_NMAX))
    else $error("multiply special not saturated");
  a_sticky_holds: assert property (!$past(acc) &&
    !$past(inexact_sticky_clear) |-> $stable(inexact_sticky_flag))
    else $error("inexact sticky changed on its own");
  a_sticky_clear: assert property (inexact_sticky_clear && !acc
    |=> !inexact_sticky_flag)
    else $error("inexact sticky not cleared");
  a_flags_held: assert property (!acc |=> $stable(invalid_input_flag_hi)
    && $stable(guard_bit_hi))
    else $error("status changed without instruction");
endmodule
bind vfm_exec vfm_exec_asserts vfm_exec_asserts_i (.*);

// *** vfm_regfile_model.sv ***
/*
  Register file model on the issue side of vfm_exec.
  Assumes the bench preloads the destination before each issue.
*/
`timescale 1ns/1ps
module vfm_regfile_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load_en,
  input wire logic [63:0] load_data,
  input wire logic [4:0] rd_index,
  input wire logic dest_write,
  input wire logic [4:0] dest_index,
  input wire logic [63:0] dest_result,
  output logic [63:0] dest_source
);
  logic [63:0] regs_reg [32];
  assign dest_source = regs_reg[rd_index];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 32; i++) begin
        regs_reg[i] <= 64'h0;
      end
    end else if (load_en) begin
      regs_reg[rd_index] <= load_data;
    end else if (dest_write) begin
      regs_reg[dest_index] <= dest_result;
    end
  end
endmodule

// *** vfm_exec_tb.sv ***
/*
  Self-checking bench of vfm_exec.
  Assumes the register file model and the bound checker.
*/
`timescale 1ns/1ps
module vfm_exec_tb;
  logic clk, resetn, issue_valid, load_en, inexact_sticky_clear;
  logic invalid_input_trap_enable, overflow_trap_enable;
  logic underflow_trap_enable, inexact_trap_enable;
  logic [31:0] instr_word;
  logic [63:0] first_source, second_source, load_data, dest_result;
  vfm_pkg::vfm_round_type round_mode;
  logic result_valid, dest_write, invalid_exception, range_exception;
  logic round_exception, invalid_input_flag_hi, invalid_input_flag_lo;
  logic overflow_flag_hi, overflow_flag_lo, underflow_flag_hi;
  logic underflow_flag_lo, guard_bit_hi, guard_bit_lo, sticky_bit_hi;
  logic sticky_bit_lo, inexact_sticky_flag;
  logic [4:0] dest_index;
  wire logic [4:0] rd_index = instr_word[25:21];
  wire logic [63:0] dest_source;
  wire logic [10:0] st = {invalid_input_flag_hi, invalid_input_flag_lo,
    overflow_flag_hi, overflow_flag_lo, underflow_flag_hi,
    underflow_flag_lo, guard_bit_hi, guard_bit_lo, sticky_bit_hi,
    sticky_bit_lo, inexact_sticky_flag};
  wire logic [4:0] ev = {result_valid, dest_write, invalid_exception,
    range_exception, round_exception};
  int err_count, num_checks;
  vfm_exec vfm_exec_i (.*);
  vfm_regfile_model vfm_regfile_model_i (.*);
  always #4 clk = ~clk;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [63:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic run(input logic [10:0] x, input logic [63:0] a, b, d,
    er, input logic [10:0] es, m, input logic [4:0] ee);
    instr_word = {6'h04, 5'h03, 10'h000, x};
    load_data = d;
    load_en = 1'b1;
    inexact_sticky_clear = 1'b1;
    first_source = a;
    second_source = b;
    @(negedge clk);
    load_en = 1'b0;
    inexact_sticky_clear = 1'b0;
    issue_valid = 1'b1;
    @(negedge clk);
    issue_valid = 1'b0;
    chk("events", 64'(ev), 64'(ee));
    chk("status", 64'(st & m), 64'(es & m));
    if (ee[3]) begin
      chk("result", dest_result, er);
      chk("index", 64'(dest_index), 64'h3);
    end
    @(negedge clk);
    chk("regfile", dest_source, ee[3] ? er : d);
    $display("test x=%h done", x);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #(400 * 8);
    err_count++;
    wrap_up();
  end
  initial begin
    {clk, resetn, issue_valid, load_en, inexact_sticky_clear} = 5'h00;
    {invalid_input_trap_enable, overflow_trap_enable} = 2'h0;
    {underflow_trap_enable, inexact_trap_enable} = 2'h0;
    {instr_word, first_source, second_source, load_data} = '0;
    round_mode = vfm_pkg::VFM_RND_NEAR;
    repeat (16) @(negedge clk);
    chk("reset", 64'({ev, st}), 64'h0);
    resetn = 1'b1;
    run(11'h2b1, 64'h3f800000_00000000, 64'h40000000_80000000, 64'h0,
      64'h3f800000_80000000, 11'h000, 11'h7ff, 5'h18);
    run(11'h2b1, 64'h7fc00000_ff800000, 64'h40000000_3f800000, 64'h0,
      64'h40000000_ff7fffff, 11'h600, 11'h7ff, 5'h18);
    run(11'h2b1, 64'h00000001_80000001, 64'h3f800000_3f800000, 64'h0,
      64'h00000000_80000000, 11'h600, 11'h7ff, 5'h18);
    invalid_input_trap_enable = 1'b1;
    run(11'h2b1, 64'h7fc00000_ff800000, 64'h40000000_3f800000, 64'h7,
      64'h0, 11'h600, 11'h7ff, 5'h14);
    invalid_input_trap_enable = 1'b0;
    run(11'h2b8, 64'h40000000_40400000, 64'h40400000_c0000000, 64'h0,
      64'h40c00000_c0c00000, 11'h000, 11'h7ff, 5'h18);
    run(11'h2b8, 64'h7f800000_00000001, 64'hc0000000_c0000000, 64'h0,
      64'hff7fffff_80000000, 11'h600, 11'h7ff, 5'h18);
    run(11'h2b8, 64'h7f000000_3f800000, 64'h7f000000_3f800000, 64'h0,
      64'h7f7fffff_3f800000, 11'h101, 11'h7ff, 5'h18);
    overflow_trap_enable = 1'b1;
    run(11'h2b8, 64'h7f000000_3f800000, 64'h7f000000_3f800000, 64'h5,
      64'h0, 11'h100, 11'h7ff, 5'h12);
    overflow_trap_enable = 1'b0;
    run(11'h2b8, 64'h3f800000_00800000, 64'h3f800000_80800000, 64'h0,
      64'h3f800000_80000000, 11'h021, 11'h7f5, 5'h18);
    underflow_trap_enable = 1'b1;
    run(11'h2b8, 64'h3f800000_00800000, 64'h3f800000_80800000, 64'h6,
      64'h0, 11'h020, 11'h7f5, 5'h12);
    underflow_trap_enable = 1'b0;
    run(11'h2b3, 64'h40000000_40000000, 64'h40400000_40400000,
      64'h3f800000_7f800000, 64'h40a00000_ff7fffff, 11'h200, 11'h7ff,
      5'h18);
    for (int i = 0; i < 4; i++) begin
      round_mode = vfm_pkg::vfm_round_type'(i);
      run(11'h2b3, 64'h00000000_00800000, 64'h3f800000_00800000,
        64'h3f800000_00000000, {32'hbf800000, i == 3 ? 32'h80000000 :
        32'h00000000}, 11'h021, 11'h7f5, 5'h18);
    end
    round_mode = vfm_pkg::VFM_RND_NEAR;
    run(11'h2ae, 64'h40000000_7fc00000, 64'h3f800000_40800000, 64'h0,
      64'h40000000_41000000, 11'h000, 11'h7ff, 5'h18);
    run(11'h2af, 64'h7fc00000_40400000, 64'hff800000_40800000, 64'h0,
      64'hff7fffff_41400000, 11'h400, 11'h7ff, 5'h18);
    inexact_trap_enable = 1'b1;
    run(11'h2b8, 64'h3f800001_3fc00000, 64'h3f800001_3f800001, 64'h0,
      64'h3f800002_3fc00001, 11'h00d, 11'h7ff, 5'h19);
    inexact_trap_enable = 1'b0;
    run(11'h2b8, 64'h3f800001_3fc00000, 64'h3f800001_3f800001, 64'h0,
      64'h3f800002_3fc00002, 11'h00d, 11'h7ff, 5'h18);
    repeat (3) @(negedge clk);
    chk("sticky held", 64'(inexact_sticky_flag), 64'h1);
    run(11'h2b0, 64'h3f800000_3f800000, 64'h3f800000_3f800000, 64'h9,
      64'h0, 11'h000, 11'h000, 5'h00);
    wrap_up();
  end
endmodule
